// [plc_pkg.sv]
// Package of register offsets, reset values and sizes for the line controller.
package plc_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int unsigned LINES    = 32;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned BE_W     = 4;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_OWN_EN    = 8'h00;
	localparam logic [7:0] OFS_OWN_DIS   = 8'h04;
	localparam logic [7:0] OFS_OWN_STAT  = 8'h08;
	localparam logic [7:0] OFS_DRV_EN    = 8'h10;
	localparam logic [7:0] OFS_DRV_DIS   = 8'h14;
	localparam logic [7:0] OFS_DRV_STAT  = 8'h18;
	localparam logic [7:0] OFS_SET_LVL   = 8'h30;
	localparam logic [7:0] OFS_CLR_LVL   = 8'h34;
	localparam logic [7:0] OFS_OUT_LVL   = 8'h38;
	localparam logic [7:0] OFS_PIN_LVL   = 8'h3c;
	localparam logic [7:0] OFS_CHG_EN    = 8'h40;
	localparam logic [7:0] OFS_CHG_DIS   = 8'h44;
	localparam logic [7:0] OFS_CHG_MASK  = 8'h48;
	localparam logic [7:0] OFS_CHG_STAT  = 8'h4c;
	localparam logic [7:0] OFS_OD_EN     = 8'h50;
	localparam logic [7:0] OFS_OD_DIS    = 8'h54;
	localparam logic [7:0] OFS_OD_STAT   = 8'h58;
	localparam logic [7:0] OFS_PU_DIS    = 8'h60;
	localparam logic [7:0] OFS_PU_EN     = 8'h64;
	localparam logic [7:0] OFS_PU_STAT   = 8'h68;
	localparam logic [7:0] OFS_SEL_A     = 8'h70;
	localparam logic [7:0] OFS_SEL_B     = 8'h74;
	localparam logic [7:0] OFS_SEL_STAT  = 8'h78;
	localparam logic [7:0] OFS_WM_EN     = 8'ha0;
	localparam logic [7:0] OFS_WM_DIS    = 8'ha4;
	localparam logic [7:0] OFS_WM_STAT   = 8'ha8;
	localparam logic [7:0] OFS_CLK_CTRL  = 8'hc0;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
	localparam logic [31:0] RST_OWNER     = 32'hffff_ffff;
	localparam logic [31:0] RST_MUXED     = 32'hffff_ffff;
	localparam logic        RST_CLK_EN    = 1'b0;

	// ------------------------------------------------------------------
	// Bus slave states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PLC_IDLE = 2'b01,
		PLC_ACK  = 2'b10
	} plc_bus_state_t;

endpackage

// [plc_setclr_reg.sv]
// Per-line status word driven by separate set and clear strobes.
`timescale 1ns/1ps
module plc_setclr_reg #(
	parameter int unsigned W        = 32,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] set_mask,
	input  wire logic [W-1:0] clr_mask,
	output logic      [W-1:0] status_q
);

	logic [W-1:0] status_d;

	// Bits written as zero leave the status alone; set wins over clear.
	assign status_d = (status_q & ~clr_mask) | set_mask;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			status_q <= RST_VAL;
		end else begin
			status_q <= status_d;
		end
	end

endmodule

// [plc_top.sv]
// Parallel line controller: set/clear register sets, pin muxing, bus slave.
`timescale 1ns/1ps
module plc_top
	import plc_pkg::*;
#(
	parameter logic [31:0] MUXED_LINES = plc_pkg::RST_MUXED,
	parameter logic [31:0] OWNER_RESET = plc_pkg::RST_OWNER
) (
	input  wire logic                         ref_clk,
	input  wire logic                         reset,
	input  wire logic [plc_pkg::ADDR_W-1:0]   avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [plc_pkg::DATA_W-1:0]   avs_writedata,
	input  wire logic [plc_pkg::BE_W-1:0]     avs_byteenable,
	output logic      [plc_pkg::DATA_W-1:0]   avs_readdata,
	output logic                              avs_waitrequest,
	input  wire logic [plc_pkg::LINES-1:0]    pin_in,
	output logic      [plc_pkg::LINES-1:0]    pin_out,
	output logic      [plc_pkg::LINES-1:0]    pin_oe,
	output logic      [plc_pkg::LINES-1:0]    pullup_en,
	input  wire logic [plc_pkg::LINES-1:0]    periph_a_out,
	input  wire logic [plc_pkg::LINES-1:0]    periph_a_oe,
	input  wire logic [plc_pkg::LINES-1:0]    periph_b_out,
	input  wire logic [plc_pkg::LINES-1:0]    periph_b_oe,
	output logic      [plc_pkg::LINES-1:0]    periph_in,
	output logic                              line_irq
);

	import plc_pkg::*;

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	plc_bus_state_t state_q;
	plc_bus_state_t state_d;
	logic           access;
	logic           capture;
	logic           wr_fire;
	logic [31:0]    lane_mask;
	logic [31:0]    wdata;

	assign access  = avs_read | avs_write;
	// Reads are captured on the first edge so the returned word is stable
	// while waitrequest is low; writes land on the completing edge.
	assign capture = (state_q == PLC_IDLE) & avs_read;
	assign wr_fire = (state_q == PLC_ACK) & avs_write;
	assign avs_waitrequest = access & (state_q != PLC_ACK);

	assign lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wdata = avs_writedata & lane_mask;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PLC_IDLE: begin
				if (access) begin
					state_d = PLC_ACK;
				end
			end
			PLC_ACK: begin
				state_d = PLC_IDLE;
			end
			default: begin
				state_d = PLC_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= PLC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------------
	// Write strobes
	// ------------------------------------------------------------------
	// Writes are decoded from the bus clock alone, never from the gated
	// line clock, so configuration always lands.
	logic [31:0] own_set;
	logic [31:0] own_clr;
	logic [31:0] drv_set;
	logic [31:0] drv_clr;
	logic [31:0] lvl_set;
	logic [31:0] lvl_clr;
	logic [31:0] chg_set;
	logic [31:0] chg_clr;
	logic [31:0] od_set;
	logic [31:0] od_clr;
	logic [31:0] pu_set;
	logic [31:0] pu_clr;
	logic [31:0] sel_set;
	logic [31:0] sel_clr;
	logic [31:0] wm_set;
	logic [31:0] wm_clr;
	logic        direct_wr;

	function automatic logic [31:0] strobe(input logic hit,
		input logic [31:0] data);
		strobe = hit ? data : 32'h0000_0000;
	endfunction

	assign own_set = strobe(wr_fire & (avs_address == OFS_OWN_EN),
		wdata & MUXED_LINES);
	assign own_clr = strobe(wr_fire & (avs_address == OFS_OWN_DIS),
		wdata & MUXED_LINES);
	assign drv_set = strobe(wr_fire & (avs_address == OFS_DRV_EN), wdata);
	assign drv_clr = strobe(wr_fire & (avs_address == OFS_DRV_DIS), wdata);
	assign chg_set = strobe(wr_fire & (avs_address == OFS_CHG_EN), wdata);
	assign chg_clr = strobe(wr_fire & (avs_address == OFS_CHG_DIS), wdata);
	assign od_set  = strobe(wr_fire & (avs_address == OFS_OD_EN), wdata);
	assign od_clr  = strobe(wr_fire & (avs_address == OFS_OD_DIS), wdata);
	assign pu_set  = strobe(wr_fire & (avs_address == OFS_PU_DIS), wdata);
	assign pu_clr  = strobe(wr_fire & (avs_address == OFS_PU_EN), wdata);
	assign sel_set = strobe(wr_fire & (avs_address == OFS_SEL_B), wdata);
	assign sel_clr = strobe(wr_fire & (avs_address == OFS_SEL_A), wdata);
	assign wm_set  = strobe(wr_fire & (avs_address == OFS_WM_EN), wdata);
	assign wm_clr  = strobe(wr_fire & (avs_address == OFS_WM_DIS), wdata);
	assign direct_wr = wr_fire & (avs_address == OFS_OUT_LVL);

	// ------------------------------------------------------------------
	// Status words
	// ------------------------------------------------------------------
	logic [31:0] own_q;
	logic [31:0] drv_q;
	logic [31:0] lvl_q;
	logic [31:0] chg_mask_q;
	logic [31:0] od_q;
	logic [31:0] pu_off_q;
	logic [31:0] sel_q;
	logic [31:0] wm_q;
	logic [31:0] own_view;

	plc_setclr_reg #(.W(LINES), .RST_VAL(OWNER_RESET)) u_owner (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (own_set),
		.clr_mask (own_clr),
		.status_q (own_q)
	);
	// Unmuxed lines always belong to the controller.
	assign own_view = own_q | ~MUXED_LINES;

	plc_setclr_reg #(.W(LINES), .RST_VAL(RST_ZERO)) u_drive (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (drv_set),
		.clr_mask (drv_clr),
		.status_q (drv_q)
	);

	// Level writes are never gated by ownership, so the first driven
	// level can be preset before handing the line to the controller.
	plc_setclr_reg #(.W(LINES), .RST_VAL(RST_ZERO)) u_level (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (lvl_set),
		.clr_mask (lvl_clr),
		.status_q (lvl_q)
	);
	assign lvl_set = strobe(wr_fire & (avs_address == OFS_SET_LVL), wdata)
		| strobe(direct_wr, avs_writedata & lane_mask & wm_q);
	assign lvl_clr = strobe(wr_fire & (avs_address == OFS_CLR_LVL), wdata)
		| strobe(direct_wr, ~avs_writedata & lane_mask & wm_q);

	plc_setclr_reg #(.W(LINES), .RST_VAL(RST_ZERO)) u_wmask (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (wm_set),
		.clr_mask (wm_clr),
		.status_q (wm_q)
	);

	plc_setclr_reg #(.W(LINES), .RST_VAL(RST_ZERO)) u_odrain (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (od_set),
		.clr_mask (od_clr),
		.status_q (od_q)
	);

	plc_setclr_reg #(.W(LINES), .RST_VAL(RST_ZERO)) u_pullup (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (pu_set),
		.clr_mask (pu_clr),
		.status_q (pu_off_q)
	);

	plc_setclr_reg #(.W(LINES), .RST_VAL(RST_ZERO)) u_select (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (sel_set),
		.clr_mask (sel_clr),
		.status_q (sel_q)
	);

	plc_setclr_reg #(.W(LINES), .RST_VAL(RST_ZERO)) u_chgmask (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.set_mask (chg_set),
		.clr_mask (chg_clr),
		.status_q (chg_mask_q)
	);

	// ------------------------------------------------------------------
	// Line clock enable
	// ------------------------------------------------------------------
	logic clk_en_q;
	logic clk_en_d;
	logic clk_en_hit;

	// The enable gates sampling, change detection and the interrupt; the set and
	// clear registers above never look at it.
	// A write with lane 0 disabled leaves the enable as it was.
	assign clk_en_hit = wr_fire & (avs_address == OFS_CLK_CTRL)
		& avs_byteenable[0];
	assign clk_en_d = clk_en_hit ? avs_writedata[0] : clk_en_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			clk_en_q <= RST_CLK_EN;
		end else begin
			clk_en_q <= clk_en_d;
		end
	end

	// ------------------------------------------------------------------
	// Pin sampling and change detection
	// ------------------------------------------------------------------
	// With the line clock off the sampled level freezes at its last
	// value and no change can be seen.
	logic [31:0] pin_lvl_q;
	logic [31:0] pin_lvl_d;
	logic [31:0] chg_stat_q;
	logic [31:0] chg_stat_d;
	logic [31:0] chg_event;
	logic [31:0] chg_rd_clr;

	assign pin_lvl_d = clk_en_q ? pin_in : pin_lvl_q;
	assign chg_event = clk_en_q ? (pin_in ^ pin_lvl_q) : 32'h0000_0000;
	assign chg_rd_clr = strobe(capture & (avs_address == OFS_CHG_STAT),
		32'hffff_ffff);
	// A change in the cycle of the clearing read is kept.
	assign chg_stat_d = (chg_stat_q & ~chg_rd_clr) | chg_event;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_lvl_q  <= RST_ZERO;
			chg_stat_q <= RST_ZERO;
		end else begin
			pin_lvl_q  <= pin_lvl_d;
			chg_stat_q <= chg_stat_d;
		end
	end

	assign line_irq = clk_en_q & (|(chg_stat_q & chg_mask_q));

	// ------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------
	logic [31:0] per_out;
	logic [31:0] per_oe;
	logic [31:0] lvl_src;
	logic [31:0] oe_src;

	assign per_out = (sel_q & periph_b_out) | (~sel_q & periph_a_out);
	assign per_oe  = (sel_q & periph_b_oe) | (~sel_q & periph_a_oe);
	assign lvl_src = (own_view & lvl_q) | (~own_view & per_out);
	assign oe_src  = (own_view & drv_q) | (~own_view & per_oe);
	// Open drain only ever pulls low; a high level releases the pin.
	assign pin_out = lvl_src & ~od_q;
	assign pin_oe  = oe_src & ~(od_q & lvl_src);
	// The pull-up follows its own status whatever drives the line.
	assign pullup_en = ~pu_off_q;
	assign periph_in = pin_in;

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [31:0] rd_mux;
	logic [31:0] rd_q;
	logic [31:0] rd_d;

	always_comb begin
		unique case (avs_address)
			OFS_OWN_STAT: rd_mux = own_view;
			OFS_DRV_STAT: rd_mux = drv_q;
			OFS_OUT_LVL:  rd_mux = lvl_q;
			OFS_PIN_LVL:  rd_mux = pin_lvl_q;
			OFS_CHG_MASK: rd_mux = chg_mask_q;
			OFS_CHG_STAT: rd_mux = chg_stat_q;
			OFS_OD_STAT:  rd_mux = od_q;
			OFS_PU_STAT:  rd_mux = pu_off_q;
			OFS_SEL_STAT: rd_mux = sel_q;
			OFS_WM_STAT:  rd_mux = wm_q;
			OFS_CLK_CTRL: rd_mux = {31'h0000_0000, clk_en_q};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// The word is held in a register so it stands through the acknowledge
	// cycle even if the addressed status changes under it.
	assign rd_d = capture ? rd_mux : rd_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rd_q <= RST_ZERO;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign avs_readdata = rd_q;

endmodule

// [plc_top_assertions.sv]
// Checker for bus timing, pull-up, input route and interrupt gating.
`timescale 1ns/1ps
module plc_chk
	import plc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] pin_in,
	input wire logic [31:0] pullup_en,
	input wire logic [31:0] periph_in,
	input wire logic        line_irq
);
	logic [31:0] wd;
	logic        clk_en_q;
	assign wd = avs_writedata & {{8{avs_byteenable[3]}},
		{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// Mirror of the line clock enable, so the gating rules can be watched.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) clk_en_q <= 1'b0;
		else if (avs_write && !avs_waitrequest &&
			avs_address == OFS_CLK_CTRL && avs_byteenable[0])
			clk_en_q <= avs_writedata[0];
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_wr(logic [7:0] a);
		avs_write && !avs_waitrequest && avs_address == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		avs_read && !avs_waitrequest && avs_address == a;
	endsequence
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus wait is not one cycle");
	pu_set_a: assert property (s_wr(OFS_PU_EN)
		|=> pullup_en == ($past(pullup_en) | $past(wd)))
		else $error("pull-up enable write wrong");
	pu_clr_a: assert property (s_wr(OFS_PU_DIS)
		|=> pullup_en == ($past(pullup_en) & ~$past(wd)))
		else $error("pull-up disable write wrong");
	pu_hold_a: assert property (!(avs_write && !avs_waitrequest &&
		(avs_address == OFS_PU_EN || avs_address == OFS_PU_DIS)) |=>
		$stable(pullup_en)) else $error("pull-up changed unasked");
	in_route_a: assert property (periph_in == pin_in)
		else $error("peripheral input differs from pin");
	irq_gate_a: assert property (!clk_en_q |-> !line_irq)
		else $error("interrupt with line clock off");
	undef_rd_a: assert property (s_rd(8'h0c) |-> avs_readdata == 32'h0)
		else $error("undefined address reads nonzero");
	pin_rd_a: assert property (s_rd(OFS_PIN_LVL) ##0 (clk_en_q &&
		$past(clk_en_q, 3) && $stable(pin_in) && $past(pin_in, 2) == pin_in)
		|-> avs_readdata == pin_in) else $error("pin level read wrong");
endmodule
bind plc_top plc_chk u_chk (.ref_clk, .reset, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .pin_in, .pullup_en, .periph_in, .line_irq);

// [plc_pin_model.sv]
// Pins, pull-ups, an outside driver and two peripherals beyond the block.
`timescale 1ns/1ps
module plc_pin_model (
	input wire logic         reset,
	input wire logic         ref_clk,
	input wire logic  [31:0] pin_out,
	input wire logic  [31:0] pin_oe,
	input wire logic  [31:0] pullup_en,
	input wire logic  [31:0] ext_lvl,
	input wire logic  [31:0] ext_en,
	input wire logic  [31:0] pat,
	input wire logic  [31:0] pat_oe,
	output logic      [31:0] pin_in,
	output logic      [31:0] periph_a_out,
	output logic      [31:0] periph_a_oe,
	output logic      [31:0] periph_b_out,
	output logic      [31:0] periph_b_oe
);
	logic [31:0] drv_lo;
	logic [31:0] drv_hi;
	logic [31:0] float_q;
	// A low driver wins, so shared lines behave as a wired AND.
	assign drv_lo = (pin_oe & ~pin_out) | (ext_en & ~ext_lvl);
	assign drv_hi = (pin_oe & pin_out) | (ext_en & ext_lvl);
	// An undriven line without pull-up changes every cycle, never stale.
	assign pin_in = ~drv_lo & (drv_hi | pullup_en | float_q);
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			float_q <= '0;
		end else begin
			float_q <= ~float_q;
		end
	end
	assign periph_a_out = pat;
	assign periph_a_oe = pat_oe;
	assign periph_b_out = ~pat;
	assign periph_b_oe = ~pat_oe;
endmodule

// [parallel_io_line_controller_tb.sv]
// Self-checking bench: register traffic against a bench model.
`timescale 1ns/1ps
module parallel_io_line_controller_tb;
	import plc_pkg::*;
	localparam logic [31:0] MUX = 32'h0fff_ffff;
	localparam logic [31:0] ORST = 32'hffff_fff0;
	localparam logic [31:0] EXT = 32'h0000_0100;
	logic        ref_clk, reset, avs_read, avs_write, avs_waitrequest, line_irq;
	logic [7:0]  avs_address;
	logic [3:0]  avs_byteenable, be;
	logic [31:0] avs_writedata, avs_readdata, pin_in, pin_out, pin_oe;
	logic [31:0] pullup_en, periph_in, periph_a_out, periph_a_oe, rd;
	logic [31:0] periph_b_out, periph_b_oe, ext_lvl, pat, pat_oe, d;
	logic [31:0] own, drv, lvl, od, pu, sel, wm, seed = 32'h00517f25;
	int          bad_count, cmp_count, k;
	logic [7:0]  cmds[16] = '{OFS_OWN_EN, OFS_OWN_DIS, OFS_DRV_EN, OFS_DRV_DIS,
		OFS_SET_LVL, OFS_CLR_LVL, OFS_OUT_LVL, OFS_OD_EN, OFS_OD_DIS, OFS_PU_DIS,
		OFS_PU_EN, OFS_SEL_A, OFS_SEL_B, OFS_WM_EN, OFS_WM_DIS, 8'h0c};
	logic [7:0]  stats[9] = '{OFS_OWN_STAT, OFS_DRV_STAT, OFS_OUT_LVL,
		OFS_OD_STAT, OFS_PU_STAT, OFS_SEL_STAT, OFS_WM_STAT, 8'h0c,
		OFS_CLK_CTRL};
	plc_top #(.MUXED_LINES(MUX), .OWNER_RESET(ORST)) uut (.ref_clk, .reset,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .pullup_en,
		.periph_a_out, .periph_a_oe, .periph_b_out, .periph_b_oe, .periph_in,
		.line_irq);
	plc_pin_model u_pins (.reset, .ref_clk, .pin_out,
		.pin_oe, .pullup_en, .ext_lvl, .ext_en(EXT), .pat, .pat_oe, .pin_in,
		.periph_a_out, .periph_a_oe, .periph_b_out, .periph_b_oe);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] exp_rd(logic [7:0] a);
		case (a)
			OFS_OWN_STAT: return own;
			OFS_DRV_STAT: return drv;
			OFS_OUT_LVL: return lvl;
			OFS_OD_STAT: return od;
			OFS_PU_STAT: return pu;
			OFS_SEL_STAT: return sel;
			OFS_WM_STAT: return wm;
			default: return 32'h0;
		endcase
	endfunction
	task automatic report_and_stop();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(logic [31:0] got, logic [31:0] exp, string msg);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// The request is held until waitrequest is seen low at a rising edge.
	task automatic bus(logic wr, logic [7:0] a, logic [31:0] dat);
		@(posedge ref_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= dat;
		avs_byteenable <= be;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] dat);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		bus(1'b1, a, dat);
		dat &= m;
		case (a)
			OFS_OWN_EN: own |= dat & MUX;
			OFS_OWN_DIS: own &= ~(dat & MUX);
			OFS_DRV_EN: drv |= dat;
			OFS_DRV_DIS: drv &= ~dat;
			OFS_SET_LVL: lvl |= dat;
			OFS_CLR_LVL: lvl &= ~dat;
			OFS_OUT_LVL: lvl = (lvl & ~(wm & m)) | (dat & wm);
			OFS_OD_EN: od |= dat;
			OFS_OD_DIS: od &= ~dat;
			OFS_PU_DIS: pu |= dat;
			OFS_PU_EN: pu &= ~dat;
			OFS_SEL_A: sel &= ~dat;
			OFS_SEL_B: sel |= dat;
			OFS_WM_EN: wm |= dat;
			OFS_WM_DIS: wm &= ~dat;
			default: ;
		endcase
	endtask
	task automatic chk_all();
		logic [31:0] eo, el;
		eo = (own & drv) | (~own & (sel ^ pat_oe));
		el = (own & lvl) | (~own & (sel ^ pat));
		cmp(pin_out, el & ~od, "pin level");
		cmp(pin_oe, eo & ~(od & el), "pin drive");
		cmp(pullup_en, ~pu, "pull-up");
		foreach (stats[j]) begin
			bus(1'b0, stats[j], 32'h0);
			cmp(rd, exp_rd(stats[j]), "register read");
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#150us;
		bad_count++;
		report_and_stop();
	end
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		be = 4'hf;
		{pat, pat_oe, ext_lvl} = {32'h0, 32'h0, 32'hffff_ffff};
		{drv, lvl, od, pu, sel, wm} = '0;
		own = ORST | ~MUX;
		reset = 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		chk_all();
		for (k = 0; k < 48; k++) begin
			d = rnd();
			be = 4'(rnd());
			wr(cmds[k % 16], d);
			pat <= rnd();
			pat_oe <= rnd();
			@(negedge ref_clk);
			chk_all();
		end
		be = 4'hf;
		wr(OFS_PU_EN, 32'hffff_ffff);
		wr(OFS_OWN_EN, 32'hffff_ffff);
		wr(OFS_DRV_DIS, 32'hffff_ffff);
		wr(OFS_CLK_CTRL, 32'h1);
		wr(OFS_CHG_EN, EXT);
		bus(1'b0, OFS_CHG_STAT, 32'h0);
		bus(1'b0, OFS_PIN_LVL, 32'h0);
		cmp(rd, 32'hffff_ffff, "pin read");
		ext_lvl <= ~EXT;
		repeat (4) @(negedge ref_clk);
		cmp({31'h0, line_irq}, 32'h1, "irq raise");
		bus(1'b0, OFS_CHG_STAT, 32'h0);
		cmp(rd, EXT, "change status");
		@(negedge ref_clk);
		cmp({31'h0, line_irq}, 32'h0, "irq clear");
		@(posedge ref_clk);
		ext_lvl <= 32'hffff_ffff;
		wr(OFS_CLK_CTRL, 32'h0);
		ext_lvl <= ~EXT;
		@(negedge ref_clk);
		cmp({31'h0, line_irq}, 32'h0, "irq gated");
		bus(1'b0, OFS_PIN_LVL, 32'h0);
		cmp(rd, 32'hffff_ffff, "frozen pin read");
		wr(OFS_CLK_CTRL, 32'h1);
		@(negedge ref_clk);
		cmp({31'h0, line_irq}, 32'h1, "irq after enable");
		bus(1'b0, OFS_CHG_STAT, 32'h0);
		cmp(rd, EXT, "pending change");
		report_and_stop();
	end
endmodule
